// ---- include/ser_pkg.sv ----
// shared constants and types for the status and event reporting block
package ser_pkg;
    // standard event register bit positions
    localparam int BIT_OPC   = 0;   // operation complete
    localparam int BIT_QUERY = 2;   // query fault
    localparam int BIT_INTF  = 3;   // internal fault
    localparam int BIT_EXEC  = 4;   // execution fault
    localparam int BIT_SYNTX = 5;   // syntax fault
    localparam int BIT_PWRUP = 7;   // power-up flag
    // status summary byte bit positions
    localparam int BIT_RESP  = 4;   // response waiting
    localparam int BIT_STD   = 5;   // standard summary
    localparam int BIT_MSS   = 6;   // master summary / service request
    // writable bits of each register; unused bits read as zero
    localparam logic [7:0] STD_USED   = 8'hbd;
    localparam logic [7:0] DEV0_USED  = 8'hdf;
    localparam logic [7:0] DEV1_USED  = 8'h7f;
    localparam logic [7:0] DEV2_USED  = 8'hff;
    localparam logic [7:0] DEV3_USED  = 8'hff;
    localparam logic [7:0] SRQ_USED   = 8'hbf;
    localparam logic [7:0] ZERO_BYTE  = 8'h00;
    // device register 1 judgement positions
    localparam int BIT_PPASS = 1;
    localparam int BIT_SPASS = 4;
    localparam int BIT_AND   = 6;
    // register selector for queries and mask writes
    typedef enum logic [3:0] {
        SEL_STB  = 4'h0,   // status summary byte
        SEL_SRE  = 4'h1,   // service request mask
        SEL_ESR  = 4'h2,   // standard event register
        SEL_ESE  = 4'h3,   // standard event mask
        SEL_DR0  = 4'h4,   // device event registers 0..3
        SEL_DR1  = 4'h5,
        SEL_DR2  = 4'h6,
        SEL_DR3  = 4'h7,
        SEL_DM0  = 4'h8,   // device event masks 0..3
        SEL_DM1  = 4'h9,
        SEL_DM2  = 4'ha,
        SEL_DM3  = 4'hb
    } ser_sel_t;
    // operation-complete tracking
    typedef enum logic [0:0] {
        OPC_IDLE = 1'b0,
        OPC_WAIT = 1'b1
    } ser_opc_t;
endpackage : ser_pkg

// ---- rtl/ser_evreg.sv ----
// one latched 8-bit event register with enable mask and summary output
`timescale 1ns/1ps
module ser_evreg (
    input  wire logic       i_clk,     // system clock
    input  wire logic       i_srst,    // sync reset, high
    input  wire logic [7:0] i_used,    // implemented bit positions
    input  wire logic [7:0] i_set,     // event pulses
    input  wire logic       i_clear,   // clear-status or own query
    input  wire logic       i_mask_we, // mask write strobe
    input  wire logic [7:0] i_mask_wd, // mask write data
    output logic      [7:0] o_event,   // latched events
    output logic      [7:0] o_mask,    // enable mask
    output logic            o_summary  // or of enabled events
);
    import ser_pkg::*;
    // events latch until cleared; a new event in the clear cycle survives
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            o_event <= ZERO_BYTE;
        end else if (i_clear) begin
            o_event <= i_set & i_used;
        end else begin
            o_event <= (o_event | i_set) & i_used;
        end
    end
    // mask resets to zero and keeps only implemented bits
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            o_mask <= ZERO_BYTE;
        end else if (i_mask_we) begin
            o_mask <= i_mask_wd & i_used;
        end
    end
    // summary is continuous and combinational over the latched state
    assign o_summary = |(o_event & o_mask);
endmodule : ser_evreg

// ---- rtl/ser_top.sv ----
// status and event reporting block: event registers, summary, requests
`timescale 1ns/1ps
module ser_top (
    input  wire logic             I_CLK,          // 200 MHz system clock
    input  wire logic             I_SRST,         // sync reset / power-up
    // register access from the command parser
    input  wire logic             I_RD,           // query strobe
    input  wire logic             I_WR,           // mask write strobe
    input  wire ser_pkg::ser_sel_t I_SEL,         // register selector
    input  wire logic [7:0]       I_WDATA,        // mask write data
    input  wire logic             I_CLS,          // clear-status command
    // standard events from parser, executor and queue
    input  wire logic             I_SYNTAX_ERR,   // syntax fault pulse
    input  wire logic             I_EXEC_ERR,     // execution fault pulse
    input  wire logic             I_INTERNAL_ERR, // internal fault pulse
    input  wire logic             I_QUERY_ERR,    // query fault pulse
    input  wire logic             I_OPC_CMD,      // operation-complete cmd
    input  wire logic             I_PENDING,      // earlier messages busy
    input  wire logic             I_SUPPLY_RECOV, // supply failure recovered
    // device events from measurement and comparator
    input  wire logic [7:0]       I_MEAS_EV,      // device register 0 set
    input  wire logic [5:0]       I_JUDGE_EV,     // register 1 bits 0..5
    input  wire logic [7:0]       I_BIN_LO_EV,    // bins 1..8
    input  wire logic [7:0]       I_BIN_HI_EV,    // bins 9..14, no bin, sec
    // interface state
    input  wire logic             I_RESP_AVAIL,   // output queue not empty
    input  wire logic             I_SERIAL_LINK,  // serial link selected
    input  wire logic             I_SERIAL_POLL,  // serial poll pulse
    input  wire logic             I_DEV_CLEAR,    // device clear / selected
    input  wire logic             I_BUS_TRIG,     // group execute trigger
    input  wire logic             I_EXT_TRIG_SEL, // external source chosen
    input  wire logic             I_GO_LOCAL,     // go-to-local
    input  wire logic             I_LOCKOUT,      // local lockout
    input  wire logic             I_REMOTE,       // addressed to remote
    input  wire logic             I_TERMINATOR,   // message terminator seen
    // outputs
    output logic [7:0]            O_RDATA,        // query answer
    output logic                  O_RVALID,       // answer valid pulse
    output logic                  O_SRQ,          // service request line
    output logic                  O_CLR_OUTQ,     // empty output queue
    output logic                  O_CLR_INBUF,    // empty input buffer
    output logic                  O_DISCARD,      // drop cmds to terminator
    output logic                  O_SAMPLE,       // one sampling pass
    output logic                  O_REMOTE,       // remote state
    output logic                  O_KEYS_LOCKED   // all front keys disabled
);
    import ser_pkg::*;

    logic [7:0] std_set;                 // standard event set pulses
    logic [7:0] dev_set [4];             // device event set pulses
    logic [7:0] ev      [5];             // latched event registers
    logic [7:0] msk     [5];             // enable masks
    logic [4:0] summ;                    // per-register summaries
    logic [4:0] clr;                     // per-register clears
    logic [4:0] mwe;                     // per-register mask writes
    logic [7:0] used    [5];             // implemented bits per register
    logic [7:0] srq_mask_q;              // service request mask
    logic [7:0] stb_raw;                 // summary byte without bit 6
    logic [7:0] stb_full;                // summary byte as answered
    logic [7:0] stb_prev_q;              // last enabled summary bits
    logic       master_summary_bit;                     // master summary, combinational
    logic       srq_q;                   // service request flag
    logic       pwr_q;                   // first cycle after reset
    ser_opc_t   opc_q;                   // operation-complete tracker
    logic       opc_done;                // drain finished this cycle
    logic       discard_q;               // discarding to terminator
    logic       remote_q;                // remote state
    logic       lock_q;                  // lockout state

    // query selector match, used for clear-on-read and mask writes
    function automatic logic sel_is(input ser_sel_t s, input ser_sel_t t);
        sel_is = (s == t);
    endfunction : sel_is

    // power-up flag is raised in the first cycle after reset release
    always_ff @(posedge I_CLK) begin
        if (I_SRST) begin
            pwr_q <= 1'b1;
        end else begin
            pwr_q <= 1'b0;
        end
    end

    // operation complete waits for earlier messages to finish
    always_ff @(posedge I_CLK) begin
        if (I_SRST) begin
            opc_q <= OPC_IDLE;
        end else begin
            case (opc_q)
                OPC_IDLE: begin
                    if (I_OPC_CMD && I_PENDING) begin
                        opc_q <= OPC_WAIT;
                    end
                end
                OPC_WAIT: begin
                    if (!I_PENDING) begin
                        opc_q <= OPC_IDLE;
                    end
                end
                default: opc_q <= OPC_IDLE;
            endcase
        end
    end
    assign opc_done = (I_OPC_CMD && !I_PENDING) ||
                      (opc_q == OPC_WAIT && !I_PENDING);

    // standard event pulses; user and control request bits stay zero
    always_comb begin
        std_set            = ZERO_BYTE;
        std_set[BIT_PWRUP] = pwr_q | I_SUPPLY_RECOV;
        std_set[BIT_SYNTX] = I_SYNTAX_ERR;
        std_set[BIT_EXEC]  = I_EXEC_ERR;
        std_set[BIT_INTF]  = I_INTERNAL_ERR;
        std_set[BIT_QUERY] = I_QUERY_ERR;
        std_set[BIT_OPC]   = opc_done;
    end

    // device event pulses laid out per register
    always_comb begin
        dev_set[0] = I_MEAS_EV;
        dev_set[1] = {2'b00, I_JUDGE_EV};
        dev_set[1][BIT_AND] = I_JUDGE_EV[BIT_PPASS] &
                              I_JUDGE_EV[BIT_SPASS];
        dev_set[2] = I_BIN_LO_EV;
        dev_set[3] = I_BIN_HI_EV;
    end

    assign used[0] = STD_USED;
    assign used[1] = DEV0_USED;
    assign used[2] = DEV1_USED;
    assign used[3] = DEV2_USED;
    assign used[4] = DEV3_USED;

    // clears: clear-status for all, query clears only the one read
    assign clr[0] = I_CLS | (I_RD && sel_is(I_SEL, SEL_ESR));
    assign clr[1] = I_CLS | (I_RD && sel_is(I_SEL, SEL_DR0));
    assign clr[2] = I_CLS | (I_RD && sel_is(I_SEL, SEL_DR1));
    assign clr[3] = I_CLS | (I_RD && sel_is(I_SEL, SEL_DR2));
    assign clr[4] = I_CLS | (I_RD && sel_is(I_SEL, SEL_DR3));
    // only masks accept writes; status registers ignore them
    assign mwe[0] = I_WR && sel_is(I_SEL, SEL_ESE);
    assign mwe[1] = I_WR && sel_is(I_SEL, SEL_DM0);
    assign mwe[2] = I_WR && sel_is(I_SEL, SEL_DM1);
    assign mwe[3] = I_WR && sel_is(I_SEL, SEL_DM2);
    assign mwe[4] = I_WR && sel_is(I_SEL, SEL_DM3);

    // five event registers: standard first, then device 0..3
    genvar g;
    generate
        for (g = 0; g < 5; g++) begin : g_reg
            ser_evreg u_reg (
                .i_clk     (I_CLK),
                .i_srst    (I_SRST),
                .i_used    (used[g]),
                .i_set     ((g == 0) ? std_set : dev_set[(g == 0) ? 0 : g-1]),
                .i_clear   (clr[g]),
                .i_mask_we (mwe[g]),
                .i_mask_wd (I_WDATA),
                .o_event   (ev[g]),
                .o_mask    (msk[g]),
                .o_summary (summ[g])
            );
        end
    endgenerate

    // service request mask, bit 6 not maskable and reads zero
    always_ff @(posedge I_CLK) begin
        if (I_SRST) begin
            srq_mask_q <= ZERO_BYTE;
        end else if (I_WR && sel_is(I_SEL, SEL_SRE)) begin
            srq_mask_q <= I_WDATA & SRQ_USED;
        end
    end

    // summary byte, bit 6 added below
    always_comb begin
        stb_raw          = ZERO_BYTE;
        stb_raw[3:0]     = summ[4:1];
        stb_raw[BIT_RESP] = I_RESP_AVAIL & ~I_SERIAL_LINK;
        stb_raw[BIT_STD] = summ[0];
    end
    // master summary follows the enabled events, clears with them
    assign master_summary_bit = |(stb_raw & srq_mask_q);
    // answer form of the byte carries the master bit at its own position
    always_comb begin
        stb_full          = stb_raw;
        stb_full[BIT_MSS] = master_summary_bit;
    end

    // request raised on a zero-to-one of any enabled summary bit
    always_ff @(posedge I_CLK) begin
        if (I_SRST) begin
            stb_prev_q <= ZERO_BYTE;
            srq_q      <= 1'b0;
        end else begin
            stb_prev_q <= stb_raw & srq_mask_q;
            if (|((stb_raw & srq_mask_q) & ~stb_prev_q)) begin
                srq_q <= 1'b1;
            end else if (I_SERIAL_POLL) begin
                srq_q <= 1'b0;
            end
        end
    end

    // query answers one cycle after the strobe; reads see pre-clear value
    always_ff @(posedge I_CLK) begin
        if (I_SRST) begin
            O_RDATA  <= ZERO_BYTE;
            O_RVALID <= 1'b0;
        end else begin
            O_RVALID <= I_RD;
            if (I_RD) begin
                case (I_SEL)
                    SEL_STB: O_RDATA <= stb_full;
                    SEL_SRE: O_RDATA <= srq_mask_q;
                    SEL_ESR: O_RDATA <= ev[0];
                    SEL_ESE: O_RDATA <= msk[0];
                    SEL_DR0: O_RDATA <= ev[1];
                    SEL_DR1: O_RDATA <= ev[2];
                    SEL_DR2: O_RDATA <= ev[3];
                    SEL_DR3: O_RDATA <= ev[4];
                    SEL_DM0: O_RDATA <= msk[1];
                    SEL_DM1: O_RDATA <= msk[2];
                    SEL_DM2: O_RDATA <= msk[3];
                    SEL_DM3: O_RDATA <= msk[4];
                    default: O_RDATA <= ZERO_BYTE;
                endcase
            end
        end
    end

    // service request line straight from its flag
    assign O_SRQ = srq_q;

    // queue and buffer clears, trigger, one-cycle pulses
    always_ff @(posedge I_CLK) begin
        if (I_SRST) begin
            O_CLR_OUTQ  <= 1'b0;
            O_CLR_INBUF <= 1'b0;
            O_SAMPLE    <= 1'b0;
        end else begin
            O_CLR_OUTQ  <= I_QUERY_ERR | I_DEV_CLEAR;
            O_CLR_INBUF <= I_DEV_CLEAR;
            O_SAMPLE    <= I_BUS_TRIG & I_EXT_TRIG_SEL;
        end
    end

    // discard after syntax fault until the terminator arrives or a device clear
    always_ff @(posedge I_CLK) begin
        if (I_SRST) begin
            discard_q <= 1'b0;
        end else if (I_TERMINATOR || I_DEV_CLEAR) begin
            discard_q <= 1'b0;
        end else if (I_SYNTAX_ERR) begin
            discard_q <= 1'b1;
        end
    end
    assign O_DISCARD = discard_q;

    // remote and lockout state; lockout survives go-to-local
    always_ff @(posedge I_CLK) begin
        if (I_SRST) begin
            remote_q <= 1'b0;
            lock_q   <= 1'b0;
        end else begin
            if (I_GO_LOCAL) begin
                remote_q <= 1'b0;
            end else if (I_REMOTE) begin
                remote_q <= 1'b1;
            end
            if (I_LOCKOUT) begin
                lock_q <= 1'b1;
            end
        end
    end
    assign O_REMOTE      = remote_q;
    assign O_KEYS_LOCKED = lock_q;

    // assertions
    property p_srq_rise;
        @(posedge I_CLK) disable iff (I_SRST)
        (|((stb_raw & srq_mask_q) & ~stb_prev_q)) |=> O_SRQ;
    endproperty
    a_srq_rise: assert property (p_srq_rise)
        else $error("request not raised on enabled rise");
    property p_poll_clear;
        @(posedge I_CLK) disable iff (I_SRST)
        (O_SRQ && I_SERIAL_POLL &&
         !(|((stb_raw & srq_mask_q) & ~stb_prev_q))) |=> !O_SRQ;
    endproperty
    a_poll_clear: assert property (p_poll_clear)
        else $error("serial poll did not clear request");
    property p_esr_query_clear;
        @(posedge I_CLK) disable iff (I_SRST)
        (I_RD && I_SEL == SEL_ESR && std_set == ZERO_BYTE) |=>
        (ev[0] == ZERO_BYTE);
    endproperty
    a_esr_query_clear: assert property (p_esr_query_clear)
        else $error("standard register not cleared by query");
    property p_pwrup;
        @(posedge I_CLK) $fell(I_SRST) |=> ev[0][BIT_PWRUP];
    endproperty
    a_pwrup: assert property (p_pwrup)
        else $error("power-up flag missing");
    property p_trig;
        @(posedge I_CLK) disable iff (I_SRST)
        (I_BUS_TRIG && !I_EXT_TRIG_SEL) |=> !O_SAMPLE;
    endproperty
    a_trig: assert property (p_trig)
        else $error("sample on trigger without external source");
    property p_and_bit;
        @(posedge I_CLK) disable iff (I_SRST)
        (!clr[2] && I_JUDGE_EV[BIT_PPASS] && I_JUDGE_EV[BIT_SPASS])
        |=> ev[2][BIT_AND];
    endproperty
    a_and_bit: assert property (p_and_bit)
        else $error("pass-and bit not set");
    property p_serial_resp;
        @(posedge I_CLK) disable iff (I_SRST)
        (I_RD && I_SEL == SEL_STB && I_SERIAL_LINK) |=>
        !O_RDATA[BIT_RESP];
    endproperty
    a_serial_resp: assert property (p_serial_resp)
        else $error("response bit set on serial link");
    property p_devclr;
        @(posedge I_CLK) disable iff (I_SRST)
        I_DEV_CLEAR |=> (O_CLR_OUTQ && O_CLR_INBUF);
    endproperty
    a_devclr: assert property (p_devclr)
        else $error("device clear did not empty queues");
endmodule : ser_top

// ---- verif/ser_ctl_model.sv ----
// remote controller model issuing interface-level bus commands
`timescale 1ns/1ps
module ser_ctl_model (
    input  wire logic       i_clk,  // system clock
    output logic      [5:0] o_cmd   // poll,clear,trig,local,lockout,remote
);
    // bus idle: no command asserted until the host speaks
    initial o_cmd = 6'h00;
    // one command held for exactly one edge; dly models a slow host
    task automatic send(input logic [5:0] c, input int dly);
        repeat (dly) @(posedge i_clk);
        @(posedge i_clk);
        o_cmd <= c;
        @(posedge i_clk);
        o_cmd <= 6'h00;  // released right after the sampling edge
        #1;
    endtask : send
endmodule : ser_ctl_model

// ---- verif/tb_top.sv ----
// self-checking bench for the status and event reporting block
`timescale 1ns/1ps
module tb_top;
    import ser_pkg::*;
    logic       I_CLK = 1'b0;        // 200 MHz clock
    logic       I_SRST = 1'b1;       // power-up reset
    logic       rd_q = 1'b0;         // query strobe
    logic       wr_q = 1'b0;         // mask write strobe
    ser_sel_t   sel = SEL_STB;       // register selector
    logic [7:0] wd = 8'h00;          // write data
    logic [7:0] ev = 8'h00;          // term,cls,recov,opc,qry,int,exe,syn
    logic [7:0] dv [4] = '{default: 8'h00}; // device event pulses
    logic       pend = 1'b0;         // earlier messages busy
    logic       resp = 1'b0;         // output queue not empty
    logic       ser = 1'b0;          // serial link selected
    logic       ext = 1'b0;          // external trigger source
    logic [5:0] cmd;                 // bus commands from the host model
    logic [7:0] rdata;               // query answer
    logic [7:0] st;                  // flag outputs packed for compares
    logic [7:0] lvl = 8'h00;         // level outputs expected to stand
    int         num_errors = 0;      // mismatches seen
    int         total_checks = 0;    // compares made
    // 5 ns period
    always #2.5 I_CLK = ~I_CLK;
    ser_ctl_model u_ctl (.i_clk(I_CLK), .o_cmd(cmd));
    ser_top u_dut (
        .I_CLK(I_CLK), .I_SRST(I_SRST), .I_RD(rd_q), .I_WR(wr_q),
        .I_SEL(sel), .I_WDATA(wd), .I_CLS(ev[6]), .I_SYNTAX_ERR(ev[0]),
        .I_EXEC_ERR(ev[1]), .I_INTERNAL_ERR(ev[2]), .I_QUERY_ERR(ev[3]),
        .I_OPC_CMD(ev[4]), .I_PENDING(pend), .I_SUPPLY_RECOV(ev[5]),
        .I_MEAS_EV(dv[0]), .I_JUDGE_EV(dv[1][5:0]), .I_BIN_LO_EV(dv[2]),
        .I_BIN_HI_EV(dv[3]), .I_RESP_AVAIL(resp), .I_SERIAL_LINK(ser),
        .I_SERIAL_POLL(cmd[0]), .I_DEV_CLEAR(cmd[1]), .I_BUS_TRIG(cmd[2]),
        .I_EXT_TRIG_SEL(ext), .I_GO_LOCAL(cmd[3]), .I_LOCKOUT(cmd[4]),
        .I_REMOTE(cmd[5]), .I_TERMINATOR(ev[7]), .O_RDATA(rdata),
        .O_RVALID(st[0]), .O_SRQ(st[1]), .O_CLR_OUTQ(st[7]),
        .O_CLR_INBUF(st[6]), .O_DISCARD(st[5]), .O_SAMPLE(st[4]),
        .O_REMOTE(st[3]), .O_KEYS_LOCKED(st[2]));
    // compare with case equality so unknowns never match
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // query: answer and valid come exactly one edge after the strobe
    task automatic rd(input ser_sel_t s, input logic [7:0] exp);
        @(posedge I_CLK);
        rd_q <= 1'b1;
        sel <= s;
        @(posedge I_CLK);
        rd_q <= 1'b0;
        #1;
        chk(st, lvl | 8'h01);
        chk(rdata, exp);
    endtask : rd
    // mask write, one-cycle strobe
    task automatic wr(input ser_sel_t s, input logic [7:0] d);
        @(posedge I_CLK);
        wr_q <= 1'b1;
        sel <= s;
        wd <= d;
        @(posedge I_CLK);
        wr_q <= 1'b0;
    endtask : wr
    // one-cycle pulse on standard event and command inputs
    task automatic pev(input logic [7:0] m);
        @(posedge I_CLK);
        ev <= m;
        @(posedge I_CLK);
        ev <= 8'h00;
        #1;
    endtask : pev
    // one-cycle pulse into device event register k
    task automatic dev(input int k, input logic [7:0] v);
        @(posedge I_CLK);
        dv[k] <= v;
        @(posedge I_CLK);
        dv[k] <= 8'h00;
    endtask : dev
    // single exit point of the run
    task automatic give_verdict();
        if (num_errors == 0 && total_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : give_verdict
    // a hang counts as a mismatch
    initial begin
        #50000;
        num_errors++;
        give_verdict();
    end
    // main sequence
    initial begin
        logic [7:0] dexp [4];
        dexp = '{8'hdf, 8'h7f, 8'hff, 8'hff};
        repeat (20) @(posedge I_CLK);
        I_SRST <= 1'b0;
        repeat (2) @(posedge I_CLK);
        rd(SEL_ESR, 8'h80);
        rd(SEL_ESR, 8'h00);
        rd(SEL_SRE, 8'h00);
        rd(SEL_ESE, 8'h00);
        for (int i = 0; i < 4; i++) begin
            rd(ser_sel_t'(4'(8 + i)), 8'h00);
        end
        pev(8'h01);
        chk(st, 8'h20);
        pev(8'h80);
        chk(st, 8'h00);
        pev(8'h08);
        chk(st, 8'h80);
        pev(8'h06);
        rd(SEL_ESR, 8'h3c);
        rd(SEL_ESR, 8'h00);
        wr(SEL_SRE, 8'hff);
        rd(SEL_SRE, 8'hbf);
        wr(SEL_SRE, 8'h20);
        wr(SEL_ESE, 8'h10);
        pev(8'h04);
        rd(SEL_STB, 8'h00);
        pev(8'h02);
        @(posedge I_CLK);
        #1;
        chk(st, 8'h02);
        lvl = 8'h02;
        rd(SEL_STB, 8'h60);
        u_ctl.send(6'h01, 0);
        chk(st, 8'h00);
        lvl = 8'h00;
        rd(SEL_STB, 8'h60);
        pev(8'h40);
        rd(SEL_STB, 8'h00);
        rd(SEL_ESE, 8'h10);
        pev(8'h20);
        rd(SEL_ESR, 8'h80);
        @(posedge I_CLK);
        pend <= 1'b1;
        pev(8'h10);
        rd(SEL_ESR, 8'h00);
        @(posedge I_CLK);
        pend <= 1'b0;
        repeat (2) @(posedge I_CLK);
        rd(SEL_ESR, 8'h01);
        pev(8'h10);
        rd(SEL_ESR, 8'h01);
        wr(SEL_SRE, 8'h00);
        for (int k = 0; k < 4; k++) begin
            wr(ser_sel_t'(4'(8 + k)), 8'hff);
            dev(k, 8'hff);
        end
        rd(SEL_STB, 8'h0f);
        // full events show the layout and the always-zero unused bits
        for (int k = 0; k < 4; k++) begin
            rd(ser_sel_t'(4'(4 + k)), dexp[k]);
            rd(ser_sel_t'(4'(4 + k)), 8'h00);
        end
        dev(1, 8'h12);
        rd(SEL_DR1, 8'h52);
        dev(1, 8'h02);
        rd(SEL_DR1, 8'h02);
        wr(SEL_DM2, 8'h01);
        dev(2, 8'h02);
        rd(SEL_STB, 8'h00);
        rd(SEL_DR2, 8'h02);
        wr(SEL_DR0, 8'hff);
        rd(SEL_DR0, 8'h00);
        @(posedge I_CLK);
        resp <= 1'b1;
        rd(SEL_STB, 8'h10);
        @(posedge I_CLK);
        ser <= 1'b1;
        rd(SEL_STB, 8'h00);
        u_ctl.send(6'h02, 0);
        chk(st, 8'hc0);
        @(posedge I_CLK);
        ext <= 1'b1;
        u_ctl.send(6'h04, 2);
        chk(st, 8'h10);
        @(posedge I_CLK);
        ext <= 1'b0;
        u_ctl.send(6'h04, 0);
        chk(st, 8'h00);
        u_ctl.send(6'h20, 3);
        chk(st, 8'h08);
        u_ctl.send(6'h08, 0);
        chk(st, 8'h00);
        u_ctl.send(6'h10, 0);
        chk(st, 8'h04);
        // second power-up in mid-run: flag again, masks and lockout gone
        @(posedge I_CLK);
        I_SRST <= 1'b1;
        repeat (20) @(posedge I_CLK);
        I_SRST <= 1'b0;
        repeat (2) @(posedge I_CLK);
        rd(SEL_ESR, 8'h80);
        rd(SEL_DM2, 8'h00);
        give_verdict();
    end
endmodule : tb_top
